// file: pkg/slcd_pkg.sv
// Shared constants and carrier types for the segment LCD controller.
// Assumes one 50 MHz clock (mclk) that also serves as the main oscillator clock.
// Contract
// - Display memory is 28 bytes; only low four bits exist, upper read zero.
// - Sixteen fixed segments, twelve switchable to port use, four commons.
// - Mode register is 8-bit read/write, bit or byte writable, resets to zero.
// - Mode bit 7 enables display; cleared, segments not in port use carry deselect level.
// - Mode bit 4 clear grounds commons and segments not in port use; set, those carry waveforms.
// - Mode bit 0 selects four slices when zero, three when one, 1/3 bias.
// - Clock register is 8-bit read/write, bit or byte writable, resets to zero.
// - Clock bits 3:2 pick sub clock or main clock over 2^5, 2^6, 2^7.
// - Clock bits 1:0 divide source clock by 2^6, 2^7, 2^8 or 2^9.
// - Frame rate equals display clock divided by number of slices.
// - Memory bits 0 to 3 serve common slots 0 to 3; one selects.
// - Commons activate in turn over three or four slots; common 3 idle in three.
package slcd_pkg;

    localparam logic [15:0] ADDR_MODE = 16'hffb0;
    localparam logic [15:0] ADDR_CLOCK = 16'hffb2;
    localparam logic [15:0] ADDR_MEM_BASE = 16'hfa00;
    localparam int MEM_BYTES = 28;
    localparam int SEG_FIXED = 16;
    localparam int SEG_SWITCH = 12;
    localparam int NUM_COM = 4;

    localparam int MODE_ON_BIT = 7;
    localparam int MODE_PINS_BIT = 4;
    localparam int MODE_SLICE_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_IMPL_MASK = 8'h91;
    localparam logic [7:0] CLOCK_RESET = 8'h00;
    localparam logic [7:0] CLOCK_IMPL_MASK = 8'h0f;
    localparam logic [3:0] MEM_IMPL_MASK = 4'hf;
    localparam int CLOCK_SRC_LSB = 2;
    localparam int CLOCK_DIV_LSB = 0;

    // Exponents of the power-of-two dividers
    localparam int PRE_BASE_EXP = 4;
    localparam int PRE_WIDTH = 7;
    localparam int DIV_BASE_EXP = 6;
    localparam int DIV_WIDTH = 9;

    localparam logic [1:0] SLOT_LAST_FOUR = 2'h3;
    localparam logic [1:0] SLOT_LAST_THREE = 2'h2;

    // Bias level codes: ground, one third, two thirds, full drive voltage
    localparam logic [1:0] LVL_GND = 2'h0;
    localparam logic [1:0] LVL_THIRD = 2'h1;
    localparam logic [1:0] LVL_TWO_THIRD = 2'h2;
    localparam logic [1:0] LVL_FULL = 2'h3;

    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
        logic [7:0] wmask;
    } slcd_bus_req_t;

    typedef struct packed {
        logic [PRE_WIDTH-1:0] pre;
        logic [DIV_WIDTH-1:0] div;
        logic sub_q;
        logic tick;
    } slcd_div_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] clock;
        logic [MEM_BYTES-1:0][3:0] mem;
        logic [1:0] slot;
        logic pol;
        logic [MEM_BYTES-1:0][1:0] seg;
        logic [NUM_COM-1:0][1:0] com;
        logic [7:0] rdata;
    } slcd_state_t;

endpackage : slcd_pkg

// file: logic/slcd_clkdiv.sv
// Source clock selection and display clock divider.
// Assumes sub_clk is synchronous to mclk and much slower than it.
`timescale 1ns/10ps
`default_nettype none
module slcd_clkdiv (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Control
    input wire logic run,
    input wire logic [1:0] src_sel,
    input wire logic [1:0] div_sel,
    input wire logic sub_clk,
    // One pulse per display clock period
    output logic disp_tick
);

    slcd_pkg::slcd_div_state_t st;
    slcd_pkg::slcd_div_state_t next_st;
    logic src_tick;

    function automatic logic low_ones(input logic [15:0] v, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i < n && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction : low_ones

    always_comb begin
        next_st = st;
        if (src_sel == 2'h0) begin
            src_tick = sub_clk && !st.sub_q;
        end else begin
            src_tick = low_ones(16'(st.pre), slcd_pkg::PRE_BASE_EXP + int'(src_sel));
        end
        next_st.sub_q = sub_clk;
        next_st.tick = 1'b0;
        if (!run) begin
            next_st.pre = '0;
            next_st.div = '0;
        end else begin
            next_st.pre = st.pre + 1'b1;
            if (src_tick) begin
                next_st.div = st.div + 1'b1;
                next_st.tick = low_ones(16'(st.div), slcd_pkg::DIV_BASE_EXP + int'(div_sel));
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign disp_tick = st.tick;

endmodule : slcd_clkdiv
`default_nettype wire

// file: logic/slcd_ctrl.sv
// Segment LCD controller top: control registers, display memory, drive levels.
// Assumes a synchronous CPU memory port; a read answers on the next edge.
// Pins are two-bit bias level codes; analog drivers sit outside.
`timescale 1ns/10ps
`default_nettype none
module slcd_ctrl #(
    parameter int MEM_BYTES = slcd_pkg::MEM_BYTES,
    parameter int NUM_COM = slcd_pkg::NUM_COM
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Sub clock, its rising edges counted on mclk
    input wire logic sub_clk,
    // CPU memory port
    input wire slcd_pkg::slcd_bus_req_t cpu_req,
    output logic [7:0] cpu_rdata,
    // Port function of switchable segments
    input wire logic [slcd_pkg::SEG_SWITCH-1:0] seg_port_sel,
    input wire logic [slcd_pkg::SEG_SWITCH-1:0] seg_port_data,
    // Panel drive level codes
    output logic [MEM_BYTES-1:0][1:0] seg_level,
    output logic [NUM_COM-1:0][1:0] com_level
);

    slcd_pkg::slcd_state_t st;
    slcd_pkg::slcd_state_t next_st;
    logic disp_tick;
    logic disp_on;
    logic pins_on;
    logic three_slice;
    logic [1:0] slot_last;
    logic [15:0] mem_off;
    logic [4:0] mem_idx;
    logic [MEM_BYTES-1:0] port_use;
    logic [MEM_BYTES-1:0] port_val;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_MODE,
        SEL_CLOCK,
        SEL_MEM
    } slcd_sel_t;

    slcd_sel_t sel;

    // Address decode shared by the write and read paths
    function automatic slcd_sel_t addr_decode(input logic [15:0] addr);
        slcd_sel_t r;
        r = SEL_NONE;
        if (addr == slcd_pkg::ADDR_MODE) begin
            r = SEL_MODE;
        end else if (addr == slcd_pkg::ADDR_CLOCK) begin
            r = SEL_CLOCK;
        end else if (addr >= slcd_pkg::ADDR_MEM_BASE &&
                addr - slcd_pkg::ADDR_MEM_BASE < 16'(MEM_BYTES)) begin
            // Bytes past the memory fall through as unmapped
            r = SEL_MEM;
        end
        return r;
    endfunction : addr_decode

    assign disp_on = st.mode[slcd_pkg::MODE_ON_BIT];
    assign pins_on = st.mode[slcd_pkg::MODE_PINS_BIT];
    assign three_slice = st.mode[slcd_pkg::MODE_SLICE_BIT];
    assign mem_off = cpu_req.addr - slcd_pkg::ADDR_MEM_BASE;
    assign sel = addr_decode(cpu_req.addr);
    assign mem_idx = mem_off[4:0];
    // switchable segments sit above the fixed ones
    assign port_use = MEM_BYTES'({seg_port_sel, {slcd_pkg::SEG_FIXED{1'b0}}});
    assign port_val = MEM_BYTES'({seg_port_data, {slcd_pkg::SEG_FIXED{1'b0}}});

    assign slot_last = three_slice ? slcd_pkg::SLOT_LAST_THREE : slcd_pkg::SLOT_LAST_FOUR;

    // Bit-manipulation write merge; mask of all ones is a byte write
    function automatic logic [7:0] merge(
        input logic [7:0] old,
        input logic [7:0] wdata,
        input logic [7:0] wmask,
        input logic [7:0] impl
    );
        return ((old & ~wmask) | (wdata & wmask)) & impl;
    endfunction : merge

    // Common level for a slot: selected swings to an extreme, others sit inner
    function automatic logic [1:0] com_lvl(input logic sel, input logic pol);
        logic [1:0] r;
        if (sel) begin
            r = pol ? slcd_pkg::LVL_GND : slcd_pkg::LVL_FULL;
        end else begin
            r = pol ? slcd_pkg::LVL_TWO_THIRD : slcd_pkg::LVL_THIRD;
        end
        return r;
    endfunction : com_lvl

    // Segment level: select opposes the selected common, deselect stays inner
    function automatic logic [1:0] seg_lvl(input logic sel, input logic pol);
        logic [1:0] r;
        if (sel) begin
            r = pol ? slcd_pkg::LVL_FULL : slcd_pkg::LVL_GND;
        end else begin
            r = pol ? slcd_pkg::LVL_THIRD : slcd_pkg::LVL_TWO_THIRD;
        end
        return r;
    endfunction : seg_lvl

    // clock changes assumed only while off
    slcd_clkdiv i_slcd_clkdiv (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .run(disp_on),
        .src_sel(st.clock[slcd_pkg::CLOCK_SRC_LSB +: 2]),
        .div_sel(st.clock[slcd_pkg::CLOCK_DIV_LSB +: 2]),
        .sub_clk(sub_clk),
        .disp_tick(disp_tick)
    );

    always_comb begin
        next_st = st;

        if (cpu_req.wr) begin
            unique case (sel)
                SEL_MODE: begin
                    next_st.mode = merge(st.mode, cpu_req.wdata, cpu_req.wmask,
                        slcd_pkg::MODE_IMPL_MASK);
                end
                SEL_CLOCK: begin
                    next_st.clock = merge(st.clock, cpu_req.wdata, cpu_req.wmask,
                        slcd_pkg::CLOCK_IMPL_MASK);
                end
                SEL_MEM: begin
                    next_st.mem[mem_idx] = 4'(merge({4'h0, st.mem[mem_idx]}, cpu_req.wdata,
                        cpu_req.wmask, {4'h0, slcd_pkg::MEM_IMPL_MASK}));
                end
                SEL_NONE: begin
                    // Unmapped writes are dropped
                end
            endcase
        end

        // Read and write in one cycle: the read sees the old value
        if (cpu_req.rd) begin
            unique case (sel)
                SEL_MODE: begin
                    next_st.rdata = st.mode;
                end
                SEL_CLOCK: begin
                    next_st.rdata = st.clock;
                end
                SEL_MEM: begin
                    next_st.rdata = {4'h0, st.mem[mem_idx]};
                end
                SEL_NONE: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // slot held at zero while off
        if (!disp_on) begin
            next_st.slot = 2'h0;
            next_st.pol = 1'b0;
        end else if (disp_tick) begin
            if (st.slot >= slot_last) begin
                next_st.slot = 2'h0;
                next_st.pol = !st.pol;
            end else begin
                next_st.slot = st.slot + 2'h1;
            end
        end

        for (int c = 0; c < NUM_COM; c++) begin
            // pins grounded when pin control clear
            if (!pins_on) begin
                next_st.com[c] = slcd_pkg::LVL_GND;
            end else if (three_slice && c == NUM_COM - 1) begin
                // last common idle in three slices
                next_st.com[c] = com_lvl(1'b0, st.pol);
            end else begin
                next_st.com[c] = com_lvl(st.slot == 2'(c), st.pol);
            end
        end

        for (int s = 0; s < MEM_BYTES; s++) begin
            if (port_use[s]) begin
                next_st.seg[s] = port_val[s] ? slcd_pkg::LVL_FULL : slcd_pkg::LVL_GND;
            end else if (!pins_on) begin
                next_st.seg[s] = slcd_pkg::LVL_GND;
            end else if (!disp_on) begin
                next_st.seg[s] = seg_lvl(1'b0, st.pol);
            end else begin
                next_st.seg[s] = seg_lvl(st.mem[s][st.slot], st.pol);
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.mode <= slcd_pkg::MODE_RESET;
            st.clock <= slcd_pkg::CLOCK_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign cpu_rdata = st.rdata;
    assign seg_level = st.seg;
    assign com_level = st.com;

endmodule : slcd_ctrl
`default_nettype wire

// file: tb/slcd_ctrl_checker.sv
// Port assertions for the segment LCD controller, bound to slcd_ctrl.
// Strobes count only on edges where ce is high, as in the design.
`timescale 1ns/10ps
`default_nettype none
module slcd_ctrl_checker #(
    parameter int MEM_BYTES = 28,
    parameter int NUM_COM = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire slcd_pkg::slcd_bus_req_t cpu_req,
    input wire logic [7:0] cpu_rdata,
    input wire logic [MEM_BYTES-1:0][1:0] seg_level,
    input wire logic [NUM_COM-1:0][1:0] com_level
);
    logic [7:0] m, m1, m2, m3, nm;
    logic [3:0] ext;
    logic hold, rd_mem;
    assign nm = (cpu_req.wr && cpu_req.addr == slcd_pkg::ADDR_MODE) ?
        (((m & ~cpu_req.wmask) | (cpu_req.wdata & cpu_req.wmask)) & 8'h91) : m;
    // Mode must settle for a few edges before levels follow it
    assign hold = (m == m1) && (m1 == m2) && (m2 == m3);
    assign rd_mem = ce && cpu_req.rd && cpu_req.addr >= 16'hfa00 && cpu_req.addr <= 16'hfa1b;
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            ext[k] = (com_level[k] == 2'h0) || (com_level[k] == 2'h3);
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {m3, m2, m1, m} <= 32'h0;
        end else if (ce) begin
            {m3, m2, m1, m} <= {m2, m1, m, nm};
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_pins_ground: assert property (hold && !m[4]
        |-> com_level == '0 && seg_level[15:0] == '0)
        else $error("pins not grounded");
    a_one_selected: assert property (hold && m[4] && m[7] |-> $onehot(ext))
        else $error("not exactly one common selected");
    a_off_desel: assert property (hold && m[4] && !m[7] |-> seg_level[0] == 2'h2 && ext[0])
        else $error("display off levels wrong");
    a_three_idle: assert property (hold && m[4] && m[7] && m[0] |-> !ext[3])
        else $error("common 3 used in three slices");
    a_mem_high_zero: assert property (rd_mem |=> cpu_rdata[7:4] == 4'h0)
        else $error("memory upper bits not zero");
    a_mode_readback: assert property (ce && cpu_req.rd && cpu_req.addr == 16'hffb0
        |=> cpu_rdata == $past(m))
        else $error("mode readback wrong");
    a_clock_high_zero: assert property (ce && cpu_req.rd && cpu_req.addr == 16'hffb2
        |=> cpu_rdata[7:4] == 4'h0)
        else $error("clock upper bits not zero");
    a_rdata_holds: assert property (!(ce && cpu_req.rd) |=> $stable(cpu_rdata))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (ce && cpu_req.rd && cpu_req.addr == 16'hffb1
        |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (hold && m[7] && m[0]);
    cover property (hold && m[7] && !m[0]);
    cover property (hold && m[4] && !m[7]);
endmodule : slcd_ctrl_checker
bind slcd_ctrl slcd_ctrl_checker #(.MEM_BYTES(MEM_BYTES), .NUM_COM(NUM_COM)) i_slcd_ctrl_checker (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .seg_level(seg_level), .com_level(com_level));
`default_nettype wire

// file: tb/slcd_panel.sv
// Panel model: which pixels of one segment are lit under each common.
// Assumes level codes 0 and 3 are the full-swing extremes.
`timescale 1ns/10ps
`default_nettype none
module slcd_panel (
    // Clock
    input wire logic mclk,
    // Drive levels
    input wire logic [1:0] seg,
    input wire logic [3:0][1:0] com,
    // Lit pixels
    output logic [3:0] lit
);
    initial lit = 4'h0;
    always @(posedge mclk) begin
        for (int k = 0; k < 4; k++) begin
            if (com[k] == 2'h0 || com[k] == 2'h3) begin
                lit[k] <= (seg == ~com[k]);
            end
        end
    end
endmodule : slcd_panel
`default_nettype wire

// file: tb/tb_segment_lcd_controller.sv
// Testbench for slcd_ctrl with a panel model on segment 0.
// Assumes the package constants; sub clock made here, synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module tb_segment_lcd_controller;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sub_clk = 1'b0;
    slcd_pkg::slcd_bus_req_t cpu_req = '0;
    logic [11:0] seg_port_sel = 12'h000;
    logic [11:0] seg_port_data = 12'h000;
    logic [7:0] cpu_rdata;
    logic [27:0][1:0] seg_level;
    logic [3:0][1:0] com_level;
    logic [3:0] lit;
    logic [31:0] rng = 32'd74372;
    logic [7:0] mem [28];
    logic [7:0] exp_q[$];
    logic rd_q = 1'b0;
    int errors = 0;
    int check_count = 0;
    logic ce = 1'b1;
    // Clock codes that each give 8192 mclk cycles per slot
    logic [7:0] codes [3] = '{8'h09, 8'h06, 8'h03};
    always #10 mclk = ~mclk;
    always begin
        repeat (8) @(posedge mclk);
        sub_clk <= ~sub_clk;
    end
    slcd_ctrl i_slcd_ctrl (.mclk(mclk), .rst_n(rst_n), .ce(ce), .sub_clk(sub_clk),
        .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .seg_port_sel(seg_port_sel),
        .seg_port_data(seg_port_data), .seg_level(seg_level), .com_level(com_level));
    slcd_panel i_slcd_panel (.mclk(mclk), .seg(seg_level[0]), .com(com_level), .lit(lit));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, e, g);
        end
    endtask : chk
    task automatic op(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d,
                      input logic [7:0] k);
        cpu_req <= '{addr: a, wr: w, rd: r, wdata: d, wmask: k};
        @(posedge mclk);
    endtask : op
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(a, 1'b0, 1'b1, 8'h00, 8'h00);
    endtask : rd
    task automatic period(input int e);
        logic [7:0] c0;
        int n;
        for (int p = 0; p < 2; p++) begin
            c0 = com_level;
            n = 0;
            while (com_level === c0 && n < 4 * e) begin
                @(negedge mclk);
                n++;
            end
        end
        chk("slot_len", e[15:0], n[15:0]);
        @(posedge mclk);
    endtask : period
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    // Read results taken one edge after the strobe
    always @(posedge mclk) begin
        if (rd_q) begin
            chk("cpu_rdata", {8'h00, exp_q.pop_front()}, {8'h00, cpu_rdata});
        end
        rd_q <= cpu_req.rd && ce;
    end
    initial begin
        repeat (95000) @(posedge mclk);
        errors++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(16'hffb0, 8'h00);
        rd(16'hffb2, 8'h00);
        op(16'hffb2, 1'b1, 1'b0, 8'h0f, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h11, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h91, 8'hff);
        rd(16'hffb2, 8'h0f);
        rd(16'hffb0, 8'h91);
        op(16'hffb0, 1'b1, 1'b0, 8'h00, 8'h80);
        rd(16'hffb0, 8'h11);
        op(16'hffb0, 1'b1, 1'b0, 8'h00, 8'hff);
        op(16'hffb1, 1'b1, 1'b0, 8'h55, 8'hff);
        rd(16'hffb1, 8'h00);
        // Write with ce low must not land
        ce <= 1'b0;
        op(16'hffb0, 1'b1, 1'b0, 8'h10, 8'hff);
        ce <= 1'b1;
        rd(16'hffb0, 8'h00);
        for (int i = 0; i < 28; i++) begin
            rng = xs(rng);
            mem[i] = rng[7:0];
            op(16'hfa00 + 16'(i), 1'b1, 1'b0, mem[i], 8'hff);
        end
        for (int i = 0; i < 28; i++) begin
            rd(16'hfa00 + 16'(i), {4'h0, mem[i][3:0]});
        end
        seg_port_sel <= rng[27:16];
        seg_port_data <= rng[11:0];
        op(16'hffb2, 1'b1, 1'b0, 8'h04, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h00, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h10, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h90, 8'hff);
        op(16'hffb0, 1'b0, 1'b0, 8'h00, 8'h00);
        period(2048);
        for (int f = 0; f < 2; f++) begin
            repeat (8192) @(negedge mclk);
            chk("lit4", {12'h0, mem[0][3:0]}, {12'h0, lit});
        end
        @(posedge mclk);
        op(16'hffb0, 1'b1, 1'b0, 8'h10, 8'hff);
        op(16'hffb0, 1'b0, 1'b0, 8'h00, 8'h00);
        repeat (8) @(negedge mclk);
        chk("seg_off", 16'h0002, {14'h0, seg_level[0]});
        chk("com_off", 16'h0003, {14'h0, com_level[0]});
        for (int j = 0; j < 12; j++) begin
            logic [1:0] pe;
            pe = seg_port_sel[j] ? {2{seg_port_data[j]}} : 2'h2;
            chk("seg_port", {14'h0, pe}, {14'h0, seg_level[16 + j]});
        end
        @(posedge mclk);
        op(16'hffb2, 1'b1, 1'b0, 8'h00, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h11, 8'hff);
        op(16'hffb0, 1'b1, 1'b0, 8'h91, 8'hff);
        op(16'hffb0, 1'b0, 1'b0, 8'h00, 8'h00);
        period(1024);
        for (int f = 0; f < 2; f++) begin
            repeat (3072) @(negedge mclk);
            chk("lit3", {13'h0, mem[0][2:0]}, {13'h0, lit[2:0]});
        end
        // Remaining divider codes over sources 2, 1 and 0, display off around each change
        for (int k = 0; k < 3; k++) begin
            @(posedge mclk);
            op(16'hffb0, 1'b1, 1'b0, 8'h10, 8'hff);
            op(16'hffb2, 1'b1, 1'b0, codes[k], 8'hff);
            op(16'hffb0, 1'b1, 1'b0, 8'h90, 8'hff);
            op(16'hffb0, 1'b0, 1'b0, 8'h00, 8'h00);
            period(8192);
        end
        @(posedge mclk);
        op(16'hffb0, 1'b1, 1'b0, 8'h00, 8'hff);
        op(16'hffb0, 1'b0, 1'b0, 8'h00, 8'h00);
        repeat (4) @(negedge mclk);
        chk("com_gnd", 16'h0000, {8'h0, com_level});
        stop_test();
    end
endmodule : tb_segment_lcd_controller
`default_nettype wire
